// >>> rxdw_checker.sv
// Port assertions for the receive descriptor DMA writer
`timescale 1ns/1ns
`include "rxdw_map.vh"
module rxdw_checker (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire in_valid,
    input wire in_ready,
    input wire mem_req,
    input wire mem_we,
    input wire [31:0] mem_addr,
    input wire [31:0] mem_wdata,
    input wire [3:0] mem_be,
    input wire mem_ack,
    input wire queue_error_interrupt
);
    reg [31:0] dt_reg;
    reg [31:0] q_reg;
    wire apb_wr = psel && penable && pready && pwrite;
    // Window spans keep buffer writes from looking like queue or table traffic
    wire in_q = (mem_addr[31:2] - q_reg[31:2]) < 30'h10000;
    wire in_dt = (mem_addr[31:4] - dt_reg[31:4]) < 28'h4000;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dt_reg <= 32'h0;
            q_reg <= 32'h0;
        end else if (apb_wr) begin
            if (paddr == `RXDW_DT_BASE) dt_reg <= pwdata;
            if (paddr == `RXDW_Q_BASE) q_reg <= pwdata;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_apb_wait; psel && !penable |=> pready; endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("no zero-wait answer");
    property p_apb_pulse; pready |=> !pready; endproperty
    a_apb_pulse: assert property (p_apb_pulse) else $error("pready longer than one cycle");
    property p_apb_err; pslverr |-> pready; endproperty
    a_apb_err: assert property (p_apb_err) else $error("pslverr without pready");
    property p_req_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata)
        && $stable(mem_we) && $stable(mem_be); endproperty
    a_req_hold: assert property (p_req_hold) else $error("memory request changed before ack");
    property p_req_drop; mem_req && mem_ack |=> !mem_req; endproperty
    a_req_drop: assert property (p_req_drop) else $error("request held after ack");
    property p_rq_entry; mem_req && mem_we && in_q |-> mem_be == 4'h7 && mem_wdata[23:16] == 8'h00
        && mem_wdata[15:14] != 2'b11; endproperty
    a_rq_entry: assert property (p_rq_entry) else $error("bad ready queue entry");
    property p_info; mem_req && mem_we && in_dt && mem_addr[3:0] == 4'h8 |-> !mem_wdata[15]
        && mem_wdata[6:5] == 2'b00; endproperty
    a_info: assert property (p_info) else $error("bad descriptor info word");
    property p_irq; queue_error_interrupt |=> !queue_error_interrupt; endproperty
    a_irq: assert property (p_irq) else $error("queue error not a pulse");
    property p_take; in_valid && in_ready |=> !in_ready [*2]; endproperty
    a_take: assert property (p_take) else $error("in_ready back too soon");
    cover property (mem_req && mem_ack && mem_we && in_q);
    cover property (queue_error_interrupt);
    cover property (pslverr);
endmodule
bind rxdw_writer rxdw_checker rxdw_checker_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .in_valid, .in_ready, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_be, .mem_ack,
    .queue_error_interrupt);

// >>> rxdw_host_mem.sv
// Host memory behind the bus controller port, answering with random latency
`timescale 1ns/1ns
module rxdw_host_mem (
    input wire pclk,
    input wire mem_req,
    input wire mem_we,
    input wire [31:0] mem_addr,
    input wire [31:0] mem_wdata,
    input wire [3:0] mem_be,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [logic [31:0]];
    int unsigned gap = 0;
    initial mem_ack = 1'b0;
    initial mem_rdata = 32'h0;
    always @(posedge pclk) begin
        mem_ack <= 1'b0;
        // Idle read bus toggles so stale data cannot pass
        mem_rdata <= ~mem_rdata;
        if (mem_req === 1'b1 && !mem_ack) begin
            if (gap == 0) begin
                mem_ack <= 1'b1;
                gap = $urandom % 4;
                if (!mem.exists(mem_addr)) mem[mem_addr] = 32'h0;
                if (mem_we) begin
                    for (int i = 0; i < 4; i++)
                        if (mem_be[i]) mem[mem_addr][8*i +: 8] = mem_wdata[8*i +: 8];
                end else begin
                    mem_rdata <= mem[mem_addr];
                end
            end else begin
                gap = gap - 1;
            end
        end
    end
endmodule

// >>> rxdw_map.vh
// Register map, descriptor layout and constants of the receive descriptor DMA writer
`ifndef RXDW_MAP_VH
`define RXDW_MAP_VH
`define RXDW_CTRL 8'h00
`define RXDW_DT_BASE 8'h04
`define RXDW_Q_BASE 8'h08
`define RXDW_SFQ_BND 8'h0c
`define RXDW_SFQ_WR 8'h10
`define RXDW_SFQ_RD 8'h14
`define RXDW_LFQ_BND 8'h18
`define RXDW_LFQ_WR 8'h1c
`define RXDW_LFQ_RD 8'h20
`define RXDW_RQ_BND 8'h24
`define RXDW_RQ_WR 8'h28
`define RXDW_RQ_RD 8'h2c
`define RXDW_STAT 8'h30
`define RXDW_CTRL_RST 32'h0000_0000
`define RXDW_BASE_RST 32'h0000_0000
`define RXDW_IDX_RST 16'h0000
`define RXDW_CTRL_EN 0
`define RXDW_DW_ADDR 4'h0
`define RXDW_DW_SIZE 4'h4
`define RXDW_DW_INFO 4'h8
`define RXDW_DW_NEXT 4'hc
`define RXDW_CE_BIT 7
`define RXDW_SHORT_FLAG 16'h8000
`define RXDW_RQ_GOOD 2'b00
`define RXDW_RQ_BAD 2'b01
`define RXDW_RQ_UNPROV 2'b10
`define RXDW_RQ_BE 4'h7
`define RXDW_CHANNELS 32
`endif

// >>> rxdw_writer.v
// Receive descriptor DMA writer with APB registers and host memory request port
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
`include "rxdw_map.vh"
module rxdw_writer (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire in_valid,
    output reg in_ready,
    input wire [4:0] in_chan,
    input wire [31:0] in_data,
    input wire [2:0] in_nbytes,
    input wire in_eop,
    input wire [4:0] in_status,
    input wire in_short,
    input wire in_unprov,
    output reg mem_req,
    output reg mem_we,
    output reg [31:0] mem_addr,
    output reg [31:0] mem_wdata,
    output reg [3:0] mem_be,
    input wire mem_ack,
    input wire [31:0] mem_rdata,
    output reg queue_error_interrupt
);
    localparam S_IDLE = 4'd0;
    localparam S_QRD = 4'd1;
    localparam S_D0 = 4'd2;
    localparam S_D1 = 4'd3;
    localparam S_LNK = 4'd4;
    localparam S_LNK3 = 4'd5;
    localparam S_DATA = 4'd6;
    localparam S_FIN = 4'd7;
    localparam S_RQ = 4'd8;

    reg [31:0] ctrl_reg, dt_base_reg, q_base_reg;
    reg [31:0] sfq_bnd_reg, lfq_bnd_reg, rq_bnd_reg;
    reg [15:0] sfq_wr_reg, sfq_rd_reg, lfq_wr_reg, lfq_rd_reg, rq_wr_reg, rq_rd_reg;
    reg [3:0] state_reg;
    // Per-channel table; no reset needed since act_reg gates every entry
    reg [13:0] first_ref [0:31];
    reg [13:0] cur_ref [0:31];
    reg [31:0] buf_addr [0:31];
    reg [15:0] buf_size [0:31];
    reg [15:0] used [0:31];
    reg [31:0] act_reg;
    reg [4:0] ch_reg;
    reg [31:0] data_reg;
    reg [2:0] nb_reg;
    reg eop_reg, short_reg, unprov_reg, large_reg, pick_large_reg;
    reg [4:0] st_reg;
    reg [13:0] new_ref_reg;
    reg [31:0] new_addr_reg;

    function [15:0] nxt_idx;
        input [15:0] idx;
        input [31:0] bnd;
        begin
            nxt_idx = (idx + 16'h0001 == bnd[31:16]) ? bnd[15:0] : idx + 16'h0001;
        end
    endfunction
    function [31:0] q_addr;
        input [31:0] base;
        input [15:0] idx;
        begin
            q_addr = {base[31:2], 2'b00} + {14'h0000, idx, 2'b00};
        end
    endfunction
    function [31:0] d_addr;
        input [31:0] base;
        input [13:0] dref;
        input [3:0] word;
        begin
            d_addr = {base[31:4], 4'h0} + {14'h0000, dref, 4'h0} + {28'h0000000, word};
        end
    endfunction
    wire [15:0] sfq_nxt = nxt_idx(sfq_rd_reg, sfq_bnd_reg);
    wire [15:0] lfq_nxt = nxt_idx(lfq_rd_reg, lfq_bnd_reg);
    wire [15:0] rq_nxt = nxt_idx(rq_wr_reg, rq_bnd_reg);
    wire sfq_empty = (sfq_nxt == sfq_wr_reg);
    wire lfq_empty = (lfq_nxt == lfq_wr_reg);
    wire rq_full = (rq_rd_reg == rq_wr_reg);
    wire is_first = (cur_ref[ch_reg] == first_ref[ch_reg]);
    wire [1:0] off_eff = is_first ? ctrl_reg[2:1] : 2'b00;
    wire [15:0] fill = {14'h0000, off_eff} + used[ch_reg];
    wire [15:0] cnt_out = short_reg ? (used[ch_reg] | `RXDW_SHORT_FLAG) : used[ch_reg];
    wire [5:0] st_out = {1'b0, st_reg};
    wire [1:0] rq_code = unprov_reg ? `RXDW_RQ_UNPROV : ((st_reg != 5'h00) ? `RXDW_RQ_BAD : `RXDW_RQ_GOOD);
    wire [31:0] info_w = {cnt_out, st_out, off_eff, 1'b0, 2'b00, ch_reg};
    wire apb_setup = psel & ~penable;
    wire apb_wr = psel & penable & pready & pwrite;
    wire room_ok = ({14'h0000, (cur_ref[in_chan] == first_ref[in_chan]) ? ctrl_reg[2:1] : 2'b00}
        + used[in_chan] + {13'h0000, in_nbytes}) <= buf_size[in_chan];

    reg [31:0] rd_mux;
    reg rd_err;
    always @* begin
        rd_err = 1'b0;
        case (paddr)
            `RXDW_CTRL: rd_mux = ctrl_reg;
            `RXDW_DT_BASE: rd_mux = dt_base_reg;
            `RXDW_Q_BASE: rd_mux = q_base_reg;
            `RXDW_SFQ_BND: rd_mux = sfq_bnd_reg;
            `RXDW_SFQ_WR: rd_mux = {16'h0000, sfq_wr_reg};
            `RXDW_SFQ_RD: rd_mux = {16'h0000, sfq_rd_reg};
            `RXDW_LFQ_BND: rd_mux = lfq_bnd_reg;
            `RXDW_LFQ_WR: rd_mux = {16'h0000, lfq_wr_reg};
            `RXDW_LFQ_RD: rd_mux = {16'h0000, lfq_rd_reg};
            `RXDW_RQ_BND: rd_mux = rq_bnd_reg;
            `RXDW_RQ_WR: rd_mux = {16'h0000, rq_wr_reg};
            `RXDW_RQ_RD: rd_mux = {16'h0000, rq_rd_reg};
            `RXDW_STAT: rd_mux = {28'h0000000, state_reg};
            default: begin
                rd_mux = 32'h0000_0000;
                rd_err = 1'b1;
            end
        endcase
    end

    // Zero-wait APB: answer prepared at the setup edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            ctrl_reg <= `RXDW_CTRL_RST;
            dt_base_reg <= `RXDW_BASE_RST;
            q_base_reg <= `RXDW_BASE_RST;
            sfq_bnd_reg <= `RXDW_BASE_RST;
            lfq_bnd_reg <= `RXDW_BASE_RST;
            rq_bnd_reg <= `RXDW_BASE_RST;
            sfq_wr_reg <= `RXDW_IDX_RST;
            lfq_wr_reg <= `RXDW_IDX_RST;
            rq_rd_reg <= `RXDW_IDX_RST;
        end else begin
            pready <= apb_setup;
            prdata <= (apb_setup && !pwrite) ? rd_mux : 32'h0000_0000;
            pslverr <= apb_setup & rd_err;
            if (apb_wr) begin
                case (paddr)
                    `RXDW_CTRL: ctrl_reg <= pwdata;
                    `RXDW_DT_BASE: dt_base_reg <= pwdata;
                    `RXDW_Q_BASE: q_base_reg <= pwdata;
                    `RXDW_SFQ_BND: sfq_bnd_reg <= pwdata;
                    `RXDW_SFQ_WR: sfq_wr_reg <= pwdata[15:0];
                    `RXDW_LFQ_BND: lfq_bnd_reg <= pwdata;
                    `RXDW_LFQ_WR: lfq_wr_reg <= pwdata[15:0];
                    `RXDW_RQ_BND: rq_bnd_reg <= pwdata;
                    `RXDW_RQ_RD: rq_rd_reg <= pwdata[15:0];
                    default: ctrl_reg <= ctrl_reg;
                endcase
            end
        end
    end

    always @(posedge pclk) begin
        if (state_reg == S_D1 && mem_req && mem_ack)
            buf_size[ch_reg] <= mem_rdata[15:0];
        // Old entry kept until its link words are out
        if (mem_req && mem_ack && ((state_reg == S_D1 && !act_reg[ch_reg]) || state_reg == S_LNK3)) begin
            if (!act_reg[ch_reg])
                first_ref[ch_reg] <= new_ref_reg;
            cur_ref[ch_reg] <= new_ref_reg;
            buf_addr[ch_reg] <= new_addr_reg;
            used[ch_reg] <= 16'h0000;
        end else if (state_reg == S_DATA && mem_req && mem_ack) begin
            used[ch_reg] <= used[ch_reg] + {13'h0000, nb_reg};
        end
    end

    // One outstanding request to the bus controller; each state other than S_IDLE issues then waits for ack
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= S_IDLE;
            in_ready <= 1'b0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 32'h0000_0000;
            mem_wdata <= 32'h0000_0000;
            mem_be <= 4'h0;
            queue_error_interrupt <= 1'b0;
            act_reg <= 32'h0000_0000;
            sfq_rd_reg <= `RXDW_IDX_RST;
            lfq_rd_reg <= `RXDW_IDX_RST;
            rq_wr_reg <= `RXDW_IDX_RST;
            ch_reg <= 5'h00;
            data_reg <= 32'h0000_0000;
            nb_reg <= 3'h0;
            eop_reg <= 1'b0;
            short_reg <= 1'b0;
            unprov_reg <= 1'b0;
            large_reg <= 1'b0;
            pick_large_reg <= 1'b0;
            st_reg <= 5'h00;
            new_ref_reg <= 14'h0000;
            new_addr_reg <= 32'h0000_0000;
        end else begin
            queue_error_interrupt <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (!in_ready) begin
                        in_ready <= ctrl_reg[`RXDW_CTRL_EN];
                    end else if (in_valid) begin
                        in_ready <= 1'b0;
                        ch_reg <= in_chan;
                        data_reg <= in_data;
                        nb_reg <= in_nbytes;
                        eop_reg <= in_eop;
                        st_reg <= in_status;
                        short_reg <= in_short;
                        unprov_reg <= in_unprov;
                        large_reg <= act_reg[in_chan];
                        if (!act_reg[in_chan] || !room_ok)
                            state_reg <= S_QRD;
                        else
                            state_reg <= S_DATA;
                    end
                end
                S_QRD: begin
                    if (!mem_req) begin
                        if (sfq_empty && lfq_empty) begin
                            queue_error_interrupt <= ~queue_error_interrupt;
                        end else begin
                            // Fall back to the other size class when the wanted one is empty
                            pick_large_reg <= large_reg ? !lfq_empty : sfq_empty;
                            mem_req <= 1'b1;
                            mem_we <= 1'b0;
                            mem_be <= 4'hf;
                            mem_addr <= q_addr(q_base_reg, (large_reg ? !lfq_empty : sfq_empty) ? lfq_nxt : sfq_nxt);
                        end
                    end else if (mem_ack) begin
                        mem_req <= 1'b0;
                        new_ref_reg <= mem_rdata[13:0];
                        if (pick_large_reg)
                            lfq_rd_reg <= lfq_nxt;
                        else
                            sfq_rd_reg <= sfq_nxt;
                        state_reg <= S_D0;
                    end
                end
                S_D0: begin
                    if (!mem_req) begin
                        mem_req <= 1'b1;
                        mem_addr <= d_addr(dt_base_reg, new_ref_reg, `RXDW_DW_ADDR);
                    end else if (mem_ack) begin
                        mem_req <= 1'b0;
                        new_addr_reg <= mem_rdata;
                        state_reg <= S_D1;
                    end
                end
                S_D1: begin
                    if (!mem_req) begin
                        mem_req <= 1'b1;
                        mem_addr <= d_addr(dt_base_reg, new_ref_reg, `RXDW_DW_SIZE);
                    end else if (mem_ack) begin
                        mem_req <= 1'b0;
                        state_reg <= act_reg[ch_reg] ? S_LNK : S_DATA;
                        act_reg[ch_reg] <= 1'b1;
                    end
                end
                S_LNK: begin
                    // Old descriptor closed as not last; status left zero there
                    if (!mem_req) begin
                        mem_req <= 1'b1;
                        mem_we <= 1'b1;
                        mem_addr <= d_addr(dt_base_reg, cur_ref[ch_reg], `RXDW_DW_INFO);
                        mem_wdata <= {used[ch_reg], 6'h00, off_eff, 1'b0, 2'b00, ch_reg};
                    end else if (mem_ack) begin
                        mem_req <= 1'b0;
                        state_reg <= S_LNK3;
                    end
                end
                S_LNK3: begin
                    if (!mem_req) begin
                        mem_req <= 1'b1;
                        mem_we <= 1'b1;
                        mem_addr <= d_addr(dt_base_reg, cur_ref[ch_reg], `RXDW_DW_NEXT);
                        mem_wdata <= {18'h00000, new_ref_reg};
                    end else if (mem_ack) begin
                        mem_req <= 1'b0;
                        mem_we <= 1'b0;
                        state_reg <= S_DATA;
                    end
                end
                S_DATA: begin
                    if (!mem_req) begin
                        mem_req <= 1'b1;
                        mem_we <= 1'b1;
                        mem_be <= 4'hf >> (3'd4 - nb_reg);
                        mem_addr <= buf_addr[ch_reg] + {16'h0000, fill[15:2], 2'b00};
                        mem_wdata <= data_reg;
                    end else if (mem_ack) begin
                        mem_req <= 1'b0;
                        mem_we <= 1'b0;
                        mem_be <= 4'hf;
                        state_reg <= eop_reg ? S_FIN : S_IDLE;
                    end
                end
                S_FIN: begin
                    if (!mem_req) begin
                        mem_req <= 1'b1;
                        mem_we <= 1'b1;
                        mem_addr <= d_addr(dt_base_reg, cur_ref[ch_reg], `RXDW_DW_INFO);
                        mem_wdata <= info_w | (32'h1 << `RXDW_CE_BIT);
                    end else if (mem_ack) begin
                        mem_req <= 1'b0;
                        mem_we <= 1'b0;
                        state_reg <= S_RQ;
                    end
                end
                S_RQ: begin
                    if (!mem_req) begin
                        if (!rq_full) begin
                            mem_req <= 1'b1;
                            mem_we <= 1'b1;
                            mem_be <= `RXDW_RQ_BE;
                            mem_addr <= q_addr(q_base_reg, rq_wr_reg);
                            mem_wdata <= {16'h0000, rq_code, first_ref[ch_reg]};
                        end
                    end else if (mem_ack) begin
                        mem_req <= 1'b0;
                        mem_we <= 1'b0;
                        mem_be <= 4'hf;
                        rq_wr_reg <= rq_nxt;
                        act_reg[ch_reg] <= 1'b0;
                        state_reg <= S_IDLE;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
endmodule

// >>> tb.sv
// Self-checking bench for the receive descriptor DMA writer
`timescale 1ns/1ns
`include "rxdw_map.vh"
module tb;
    typedef struct {logic we; logic [31:0] a; logic [31:0] d; logic [31:0] m; logic [3:0] b;} rxdw_note_t;
    localparam logic [31:0] QB = 32'h80000;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic in_valid = 1'b0, in_eop = 1'b0, in_short = 1'b0, in_unprov = 1'b0, e;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, in_data = 32'h0, r, d;
    logic [4:0] in_chan = 5'h0, in_status = 5'h0, ch;
    logic [2:0] in_nbytes = 3'h0;
    wire [31:0] prdata, mem_addr, mem_wdata, mem_rdata;
    wire pready, pslverr, in_ready, mem_req, mem_we, mem_ack, queue_error_interrupt;
    wire [3:0] mem_be;
    int num_errors = 0, n_compared = 0, cycles = 0, irqs = 0, seed;
    rxdw_note_t exp_q[$];
    rxdw_note_t t;
    always #20 pclk = ~pclk;
    rxdw_writer rxdw_writer_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .in_valid, .in_ready, .in_chan, .in_data, .in_nbytes, .in_eop, .in_status, .in_short,
        .in_unprov, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_be, .mem_ack, .mem_rdata,
        .queue_error_interrupt);
    rxdw_host_mem rxdw_host_mem_inst (.pclk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_be, .mem_ack,
        .mem_rdata);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out;
        if (num_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic send(input logic [31:0] wd, input logic [2:0] nb, input logic eop, input logic [4:0] st,
        input logic sh, input logic un);
        @(posedge pclk);
        in_valid <= 1'b1;
        in_chan <= ch;
        in_data <= wd;
        in_nbytes <= nb;
        in_eop <= eop;
        in_status <= st;
        in_short <= sh;
        in_unprov <= un;
        do @(posedge pclk); while (in_ready !== 1'b1);
        in_valid <= 1'b0;
        in_data <= ~wd;
    endtask
    task automatic drain;
        int n;
        n = 0;
        while ((exp_q.size() != 0 || in_ready !== 1'b1) && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        check("queue drained", exp_q.size(), 0);
        check("in_ready back", {31'h0, in_ready}, 32'h1);
    endtask
    function automatic logic [31:0] dsc(input int x);
        return 32'h1000 + 32'(x) * 16;
    endfunction
    function automatic logic [31:0] bfa(input int x);
        return 32'h100000 + 32'(x) * 256;
    endfunction
    task automatic note(input logic w, input logic [31:0] a, input logic [31:0] v, input logic [31:0] m,
        input logic [3:0] b);
        exp_q.push_back('{w, a, v, m, b});
    endtask
    task automatic fetch(input logic [31:0] qa, input int x);
        note(1'b0, qa, 32'h0, 32'h0, 4'h0);
        note(1'b0, dsc(x), 32'h0, 32'h0, 4'h0);
        note(1'b0, dsc(x) + 4, 32'h0, 32'h0, 4'h0);
    endtask
    // One-word packet: reads, data, closing info word, ready entry
    task automatic plan(input logic [31:0] qa, input int x, input logic [2:0] nb, input logic [4:0] st,
        input logic sh, input logic un, input logic [31:0] ra);
        logic [1:0] c;
        c = un ? `RXDW_RQ_UNPROV : (st != 5'h0 ? `RXDW_RQ_BAD : `RXDW_RQ_GOOD);
        d = $urandom;
        fetch(qa, x);
        note(1'b1, bfa(x), d, '1, 4'((5'h1 << nb) - 5'h1));
        note(1'b1, dsc(x) + 8, {sh, 12'h0, nb, 1'b0, st, 2'd2, 1'b1, 2'b00, ch}, '1, 4'h0);
        note(1'b1, ra, {8'h00, c, 14'(x)}, 32'h00ffffff, `RXDW_RQ_BE);
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (queue_error_interrupt === 1'b1) irqs++;
        if (cycles == 20000) begin
            num_errors++;
            close_out;
        end
    end
    always @(posedge pclk) begin
        if (mem_req === 1'b1 && mem_ack === 1'b1) begin
            t = exp_q.size() != 0 ? exp_q.pop_front() : '{1'b0, 32'hffffffff, 32'h0, 32'h0, 4'h0};
            check("mem_we", {31'h0, mem_we}, {31'h0, t.we});
            check("mem_addr", mem_addr, t.a);
            check("mem_wdata", mem_wdata & t.m, t.d & t.m);
            if (t.b != 4'h0) check("mem_be", {28'h0, mem_be}, {28'h0, t.b});
        end
    end
    initial begin
        seed = $urandom(29);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a <= 'h30; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            check("reset value", r, 32'h0);
        end
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped error", {31'h0, e}, 32'h1);
        apb(1'b1, `RXDW_SFQ_RD, 32'hffff);
        apb(1'b0, `RXDW_SFQ_RD, 32'h0);
        check("read-only index", r, 32'h0);
        check("in_ready while disabled", {31'h0, in_ready}, 32'h0);
        apb(1'b1, `RXDW_DT_BASE, 32'h1000);
        apb(1'b1, `RXDW_Q_BASE, QB);
        apb(1'b1, `RXDW_SFQ_BND, 32'h0008_0000);
        apb(1'b1, `RXDW_SFQ_WR, 32'h4);
        apb(1'b1, `RXDW_LFQ_BND, 32'h0008_0000);
        apb(1'b1, `RXDW_LFQ_WR, 32'h2);
        apb(1'b1, `RXDW_RQ_BND, 32'h0008_0000);
        apb(1'b1, `RXDW_RQ_RD, 32'h7);
        apb(1'b0, `RXDW_DT_BASE, 32'h0);
        check("table base", r, 32'h1000);
        // Host side descriptor set-up; ref 3 is tiny to force a chain
        for (int x = 1; x <= 9; x++) begin
            rxdw_host_mem_inst.mem[dsc(x)] = bfa(x);
            rxdw_host_mem_inst.mem[dsc(x) + 4] = x == 3 ? 32'h4 : 32'h40;
        end
        for (int x = 1; x <= 3; x++) rxdw_host_mem_inst.mem[QB + 4 * x] = 32'(x);
        apb(1'b1, `RXDW_CTRL, 32'h5);
        ch = 5'd5;
        plan(QB + 4, 1, 3'd4, 5'h0, 1'b0, 1'b0, QB);
        send(d, 3'd4, 1'b1, 5'h0, 1'b0, 1'b0);
        drain;
        ch = 5'd31;
        plan(QB + 8, 2, 3'd1, 5'($urandom) | 5'h1, 1'b1, 1'b0, QB + 4);
        send(d, 3'd1, 1'b1, exp_q[4].d[14:10], 1'b1, 1'b0);
        drain;
        ch = 5'($urandom);
        rxdw_host_mem_inst.mem[QB + 4] = 32'h9;
        d = $urandom;
        fetch(QB + 12, 3);
        note(1'b1, bfa(3), d, '1, 4'h3);
        send(d, 3'd2, 1'b0, 5'h0, 1'b0, 1'b0);
        drain;
        d = $urandom;
        fetch(QB + 4, 9);
        note(1'b1, dsc(3) + 8, {16'd2, 6'h0, 2'd2, 1'b0, 2'b00, ch}, 32'hffff03ff, 4'h0);
        note(1'b1, dsc(3) + 12, 32'h9, 32'h3fff, 4'h0);
        note(1'b1, bfa(9), d, '1, 4'h7);
        note(1'b1, dsc(9) + 8, {16'd3, 6'h0, 2'd0, 1'b1, 2'b00, ch}, '1, 4'h0);
        note(1'b1, QB + 8, {8'h00, `RXDW_RQ_UNPROV, 14'd3}, 32'h00ffffff, `RXDW_RQ_BE);
        send(d, 3'd3, 1'b1, 5'h0, 1'b0, 1'b1);
        drain;
        check("early queue errors", irqs, 0);
        ch = 5'd7;
        plan(QB + 8, 4, 3'd4, 5'h0, 1'b0, 1'b0, QB + 12);
        send(d, 3'd4, 1'b1, 5'h0, 1'b0, 1'b0);
        repeat (20) @(posedge pclk);
        check("queue error raised", {31'h0, irqs > 0}, 32'h1);
        rxdw_host_mem_inst.mem[QB + 8] = 32'h4;
        apb(1'b1, `RXDW_LFQ_WR, 32'h3);
        drain;
        close_out;
    end
endmodule
